// File: common/split_timer_pkg.sv
// Shared constants and types for the split capture timer
package split_timer_pkg;

  // ---------------------------------------------------------------
  // Register indices (byte address is four times the index)
  // ---------------------------------------------------------------
  localparam int ADDR_W = 12;
  localparam logic [7:0] IDX_CTRL = 8'hb9;
  localparam logic [7:0] IDX_RELOAD_LOW = 8'hba;
  localparam logic [7:0] IDX_RELOAD_HIGH = 8'hbb;
  localparam logic [7:0] IDX_COUNT_LOW = 8'hbc;
  localparam logic [7:0] IDX_COUNT_HIGH = 8'hbd;
  localparam logic [7:0] IDX_IRQ_STATUS = 8'hbe;
  localparam logic [7:0] IDX_IRQ_MASK = 8'hbf;

  // ---------------------------------------------------------------
  // Field layouts and reset values
  // ---------------------------------------------------------------
  localparam logic [7:0] BYTE_MAX = 8'hff;
  localparam logic [7:0] BYTE_RESET = 8'h00;
  localparam logic [7:0] BYTE_ONE = 8'h01;
  localparam int ST_W = 2;
  localparam int ST_LOW = 0;
  localparam int ST_HIGH = 1;
  localparam logic [ST_W-1:0] ST_RESET = 2'h0;
  localparam logic [31:0] WORD_RESET = 32'h0000_0000;

  typedef struct packed {
    logic high_irq_flag;
    logic low_irq_flag;
    logic low_irq_enable;
    logic split_select;
    logic high_capture_select;
    logic low_capture_select;
    logic high_run;
    logic low_run;
  } ctrl_t;

  localparam ctrl_t CTRL_RESET = 8'h00;

  typedef struct packed {
    logic psel;
    logic penable;
    logic pwrite;
    logic [ADDR_W-1:0] paddr;
    logic [31:0] pwdata;
  } apb_req_t;

  typedef struct packed {
    logic pready;
    logic pslverr;
    logic [31:0] prdata;
  } apb_rsp_t;

endpackage

// File: verilog/split_capture_timer_control.sv
// Split 16-bit / dual 8-bit capture and auto-reload timer with APB registers
// Function
// - High flag sets on high-half or wide overflow, or on its capture event.
// - High flag is never cleared by hardware, only by software writing zero.
// - Low flag sets on low-half overflow in timer mode or low capture in split mode.
// - Low flag is never cleared by hardware, only by software.
// - In wide timer mode low-byte overflow still sets the low flag.
// - Wide capture mode: full overflow sets low flag as seventeenth bit.
// - Wide capture mode: capture event sets only the high flag.
// - Interrupt request timer_irq is high flag or low flag with low enable.
// - Split select zero: one 16-bit timer under the low-half controls.
// - Split select one: both 8-bit halves run independently.
// - High capture select acts in split mode only, ignored in wide mode.
// - Low capture select sets low half, or whole wide timer, to capture.
// - Low run enables low half, or the whole timer in wide mode.
// - High run enables the high half in split mode.
// - Capture/reload bytes hold captured count or reload value by mode.
// - Capture/reload bytes are not double buffered; writes act at once.
`timescale 1ns/1ns
module split_capture_timer_control (
  input wire logic core_clk,
  input wire logic rst,
  input wire split_timer_pkg::apb_req_t apb_req,
  output split_timer_pkg::apb_rsp_t apb_rsp,
  input wire logic cap_low_trig,
  input wire logic cap_high_trig,
  output logic timer_irq,
  output logic irq
);

  // ---------------------------------------------------------------
  // State
  // ---------------------------------------------------------------
  split_timer_pkg::ctrl_t ctrl_q, ctrl_d;
  logic [7:0] reload_low_q, reload_low_d;
  logic [7:0] reload_high_q, reload_high_d;
  logic [7:0] count_low_q, count_low_d;
  logic [7:0] count_high_q, count_high_d;
  logic [split_timer_pkg::ST_W-1:0] stat_q, stat_d;
  logic [split_timer_pkg::ST_W-1:0] mask_q, mask_d;
  split_timer_pkg::apb_rsp_t rsp_q, rsp_d;
  logic timer_irq_q, timer_irq_d;
  logic irq_q, irq_d;

  // ---------------------------------------------------------------
  // Bus decode
  // ---------------------------------------------------------------
  logic [7:0] idx;
  logic aligned;
  logic hit;
  logic setup;
  logic wr;
  logic wr_ctrl, wr_rl, wr_rh, wr_cl, wr_ch, wr_st, wr_mk;
  logic [7:0] wbyte;

  assign idx = apb_req.paddr[9:2];
  assign aligned = (apb_req.paddr[1:0] == 2'h0) && (apb_req.paddr[11:10] == 2'h0);
  assign hit = aligned && (idx >= split_timer_pkg::IDX_CTRL) && (idx <= split_timer_pkg::IDX_IRQ_MASK);
  assign setup = apb_req.psel && !apb_req.penable;
  assign wr = apb_req.psel && apb_req.penable && apb_req.pwrite && rsp_q.pready && hit;
  assign wbyte = apb_req.pwdata[7:0];
  assign wr_ctrl = wr && (idx == split_timer_pkg::IDX_CTRL);
  assign wr_rl = wr && (idx == split_timer_pkg::IDX_RELOAD_LOW);
  assign wr_rh = wr && (idx == split_timer_pkg::IDX_RELOAD_HIGH);
  assign wr_cl = wr && (idx == split_timer_pkg::IDX_COUNT_LOW);
  assign wr_ch = wr && (idx == split_timer_pkg::IDX_COUNT_HIGH);
  assign wr_st = wr && (idx == split_timer_pkg::IDX_IRQ_STATUS);
  assign wr_mk = wr && (idx == split_timer_pkg::IDX_IRQ_MASK);

  // ---------------------------------------------------------------
  // Timer events
  // ---------------------------------------------------------------
  logic split;
  logic cap_h_mode;
  logic run_h;
  logic lo_ovf, hi_inc, hi_ovf;
  logic cap_l_ev, cap_h_ev;
  logic set_h, set_l;
  logic reload_l, reload_h;

  always_comb begin
    split = ctrl_q.split_select;
    cap_h_mode = split ? ctrl_q.high_capture_select : ctrl_q.low_capture_select;
    run_h = split && ctrl_q.high_run;
    lo_ovf = ctrl_q.low_run && (count_low_q == split_timer_pkg::BYTE_MAX);
    hi_inc = split ? run_h : lo_ovf;
    hi_ovf = hi_inc && (count_high_q == split_timer_pkg::BYTE_MAX);
    cap_l_ev = ctrl_q.low_capture_select && cap_low_trig;
    cap_h_ev = split ? (ctrl_q.high_capture_select && cap_high_trig) : cap_l_ev;
    set_h = cap_h_mode ? cap_h_ev : hi_ovf;
    if (split) begin
      set_l = ctrl_q.low_capture_select ? cap_l_ev : lo_ovf;
    end else begin
      set_l = ctrl_q.low_capture_select ? hi_ovf : lo_ovf;
    end
    reload_l = !ctrl_q.low_capture_select && (split ? lo_ovf : hi_ovf);
    reload_h = !cap_h_mode && hi_ovf;
  end

  // ---------------------------------------------------------------
  // Register next values
  // ---------------------------------------------------------------
  always_comb begin
    ctrl_d = ctrl_q;
    if (wr_ctrl) begin
      ctrl_d = wbyte;
    end
    ctrl_d.high_irq_flag = set_h || (wr_ctrl ? wbyte[7] : ctrl_q.high_irq_flag);
    ctrl_d.low_irq_flag = set_l || (wr_ctrl ? wbyte[6] : ctrl_q.low_irq_flag);

    reload_low_d = wr_rl ? wbyte : reload_low_q;
    reload_high_d = wr_rh ? wbyte : reload_high_q;
    if (cap_l_ev) begin
      reload_low_d = count_low_q;
    end
    if (cap_h_ev) begin
      reload_high_d = count_high_q;
    end

    if (wr_cl) begin
      count_low_d = wbyte;
    end else if (reload_l) begin
      count_low_d = reload_low_q;
    end else if (ctrl_q.low_run) begin
      count_low_d = count_low_q + split_timer_pkg::BYTE_ONE;
    end else begin
      count_low_d = count_low_q;
    end

    if (wr_ch) begin
      count_high_d = wbyte;
    end else if (reload_h) begin
      count_high_d = reload_high_q;
    end else if (hi_inc) begin
      count_high_d = count_high_q + split_timer_pkg::BYTE_ONE;
    end else begin
      count_high_d = count_high_q;
    end

    stat_d = stat_q & ~(wr_st ? apb_req.pwdata[split_timer_pkg::ST_W-1:0] : split_timer_pkg::ST_RESET);
    stat_d[split_timer_pkg::ST_HIGH] = stat_d[split_timer_pkg::ST_HIGH] || set_h;
    stat_d[split_timer_pkg::ST_LOW] = stat_d[split_timer_pkg::ST_LOW] || set_l;
    mask_d = wr_mk ? apb_req.pwdata[split_timer_pkg::ST_W-1:0] : mask_q;

    timer_irq_d = ctrl_d.high_irq_flag || (ctrl_d.low_irq_flag && ctrl_d.low_irq_enable);
    irq_d = |(stat_d & mask_d);
  end

  // ---------------------------------------------------------------
  // APB answer
  // ---------------------------------------------------------------
  always_comb begin
    rsp_d = rsp_q;
    rsp_d.pready = setup;
    rsp_d.pslverr = setup && !hit;
    if (setup) begin
      rsp_d.prdata = split_timer_pkg::WORD_RESET;
      if (hit && !apb_req.pwrite) begin
        unique case (idx)
          split_timer_pkg::IDX_CTRL: rsp_d.prdata[7:0] = ctrl_q;
          split_timer_pkg::IDX_RELOAD_LOW: rsp_d.prdata[7:0] = reload_low_q;
          split_timer_pkg::IDX_RELOAD_HIGH: rsp_d.prdata[7:0] = reload_high_q;
          split_timer_pkg::IDX_COUNT_LOW: rsp_d.prdata[7:0] = count_low_q;
          split_timer_pkg::IDX_COUNT_HIGH: rsp_d.prdata[7:0] = count_high_q;
          split_timer_pkg::IDX_IRQ_STATUS: rsp_d.prdata[split_timer_pkg::ST_W-1:0] = stat_q;
          split_timer_pkg::IDX_IRQ_MASK: rsp_d.prdata[split_timer_pkg::ST_W-1:0] = mask_q;
          default: rsp_d.prdata = split_timer_pkg::WORD_RESET;
        endcase
      end
    end
  end

  // ---------------------------------------------------------------
  // Flip-flops
  // ---------------------------------------------------------------
  always_ff @(posedge core_clk) begin
    if (rst) begin
      ctrl_q <= split_timer_pkg::CTRL_RESET;
      reload_low_q <= split_timer_pkg::BYTE_RESET;
      reload_high_q <= split_timer_pkg::BYTE_RESET;
      count_low_q <= split_timer_pkg::BYTE_RESET;
      count_high_q <= split_timer_pkg::BYTE_RESET;
      stat_q <= split_timer_pkg::ST_RESET;
      mask_q <= split_timer_pkg::ST_RESET;
      rsp_q <= '0;
      timer_irq_q <= 1'b0;
      irq_q <= 1'b0;
    end else begin
      ctrl_q <= ctrl_d;
      reload_low_q <= reload_low_d;
      reload_high_q <= reload_high_d;
      count_low_q <= count_low_d;
      count_high_q <= count_high_d;
      stat_q <= stat_d;
      mask_q <= mask_d;
      rsp_q <= rsp_d;
      timer_irq_q <= timer_irq_d;
      irq_q <= irq_d;
    end
  end

  assign apb_rsp = rsp_q;
  assign timer_irq = timer_irq_q;
  assign irq = irq_q;

  // ---------------------------------------------------------------
  // Assertions
  // ---------------------------------------------------------------
  property p_high_set;
    @(posedge core_clk) disable iff (rst)
      (hi_ovf && !cap_h_mode) |=> ctrl_q.high_irq_flag;
  endproperty
  a_high_set: assert property (p_high_set) else $error("high flag not set on overflow");

  property p_high_sticky;
    @(posedge core_clk) disable iff (rst)
      (ctrl_q.high_irq_flag && !(wr_ctrl && !wbyte[7])) |=> ctrl_q.high_irq_flag;
  endproperty
  a_high_sticky: assert property (p_high_sticky) else $error("high flag cleared by hardware");

  property p_low_set_split;
    @(posedge core_clk) disable iff (rst)
      (split && ((!ctrl_q.low_capture_select && lo_ovf) || cap_l_ev)) |=> ctrl_q.low_irq_flag;
  endproperty
  a_low_set_split: assert property (p_low_set_split) else $error("low flag not set in split mode");

  property p_low_sticky;
    @(posedge core_clk) disable iff (rst)
      (ctrl_q.low_irq_flag && !(wr_ctrl && !wbyte[6])) |=> ctrl_q.low_irq_flag;
  endproperty
  a_low_sticky: assert property (p_low_sticky) else $error("low flag cleared by hardware");

  property p_wide_low_ovf;
    @(posedge core_clk) disable iff (rst)
      (!split && !ctrl_q.low_capture_select && lo_ovf) |=> ctrl_q.low_irq_flag;
  endproperty
  a_wide_low_ovf: assert property (p_wide_low_ovf) else $error("low byte overflow lost in wide mode");

  property p_wide_cap17;
    @(posedge core_clk) disable iff (rst)
      (!split && ctrl_q.low_capture_select && hi_ovf) |=> ctrl_q.low_irq_flag;
  endproperty
  a_wide_cap17: assert property (p_wide_cap17) else $error("wide capture overflow not flagged");

  property p_wide_cap_high_only;
    @(posedge core_clk) disable iff (rst)
      (!split && cap_l_ev && !hi_ovf && !ctrl_q.low_irq_flag && !wr_ctrl)
        |=> (ctrl_q.high_irq_flag && !ctrl_q.low_irq_flag);
  endproperty
  a_wide_cap_high_only: assert property (p_wide_cap_high_only) else $error("wide capture set wrong flag");

  property p_irq_combine;
    @(posedge core_clk) disable iff (rst)
      ##1 (timer_irq == (ctrl_q.high_irq_flag || (ctrl_q.low_irq_flag && ctrl_q.low_irq_enable)));
  endproperty
  a_irq_combine: assert property (p_irq_combine) else $error("interrupt request mismatch");

  property p_reload_low;
    @(posedge core_clk) disable iff (rst)
      (split && lo_ovf && !ctrl_q.low_capture_select && !wr_cl) |=> (count_low_q == $past(reload_low_q));
  endproperty
  a_reload_low: assert property (p_reload_low) else $error("low half not reloaded");

  property p_capture_low;
    @(posedge core_clk) disable iff (rst)
      cap_l_ev |=> (reload_low_q == $past(count_low_q));
  endproperty
  a_capture_low: assert property (p_capture_low) else $error("low capture value wrong");

  property p_high_hold;
    @(posedge core_clk) disable iff (rst)
      (split && !ctrl_q.high_run && !wr_ch) |=> $stable(count_high_q);
  endproperty
  a_high_hold: assert property (p_high_hold) else $error("stopped high half moved");

endmodule // split_capture_timer_control

// File: bench/tb.sv
// Self-checking testbench for the split capture timer
`timescale 1ns/1ns
`define CHK(nm, exp, got) begin total_checks++; if ((got) !== (exp)) begin failures++; \
  $display("MISMATCH %s expected %h seen %h", nm, exp, got); end end
module tb;
  // ---------------------------------------------------------------
  // Clock, reset and design
  // ---------------------------------------------------------------
  logic core_clk;
  logic rst;
  split_timer_pkg::apb_req_t apb_req;
  split_timer_pkg::apb_rsp_t apb_rsp;
  logic cap_low_trig;
  logic cap_high_trig;
  logic timer_irq;
  logic irq;
  int failures;
  int total_checks;
  logic [7:0] v;
  logic e;

  split_capture_timer_control DUT (
    .core_clk(core_clk),
    .rst(rst),
    .apb_req(apb_req),
    .apb_rsp(apb_rsp),
    .cap_low_trig(cap_low_trig),
    .cap_high_trig(cap_high_trig),
    .timer_irq(timer_irq),
    .irq(irq)
  );

  initial begin
    core_clk = 1'b0;
    forever #20 core_clk = ~core_clk;
  end

  // ---------------------------------------------------------------
  // Bus and stimulus tasks
  // ---------------------------------------------------------------
  task automatic apb(input logic wr, input logic [7:0] idx, input logic [7:0] wd, output logic [7:0] rd,
                     output logic err);
    @(posedge core_clk);
    apb_req.psel <= 1'b1;
    apb_req.penable <= 1'b0;
    apb_req.pwrite <= wr;
    apb_req.paddr <= {2'h0, idx, 2'h0};
    apb_req.pwdata <= {24'h000000, wd};
    @(posedge core_clk);
    apb_req.penable <= 1'b1;
    do begin
      @(posedge core_clk);
    end while (apb_rsp.pready !== 1'b1);
    rd = apb_rsp.prdata[7:0];
    err = apb_rsp.pslverr;
    apb_req.psel <= 1'b0;
    apb_req.penable <= 1'b0;
  endtask

  task automatic wr(input logic [7:0] idx, input logic [7:0] wd);
    logic [7:0] d;
    logic x;
    apb(1'b1, idx, wd, d, x);
  endtask

  task automatic rd(input logic [7:0] idx, output logic [7:0] d);
    logic x;
    apb(1'b0, idx, 8'h00, d, x);
  endtask

  task automatic pulse(input logic high);
    @(posedge core_clk);
    if (high) cap_high_trig <= 1'b1;
    else cap_low_trig <= 1'b1;
    @(posedge core_clk);
    cap_high_trig <= 1'b0;
    cap_low_trig <= 1'b0;
    repeat (2) @(posedge core_clk);
  endtask

  // ---------------------------------------------------------------
  // Scenarios
  // ---------------------------------------------------------------
  task automatic t_reset_map;
    rd(split_timer_pkg::IDX_CTRL, v); `CHK("ctrl reset", 8'h00, v)
    rd(split_timer_pkg::IDX_RELOAD_HIGH, v); `CHK("reload reset", 8'h00, v)
    apb(1'b0, 8'hc0, 8'h00, v, e); `CHK("unmapped err", 1'b1, e)
    $display("test reset_map done");
  endtask

  task automatic t_split_irq;
    wr(split_timer_pkg::IDX_RELOAD_LOW, 8'hf0);
    rd(split_timer_pkg::IDX_RELOAD_LOW, v); `CHK("reload write", 8'hf0, v)
    wr(split_timer_pkg::IDX_COUNT_LOW, 8'hfd);
    wr(split_timer_pkg::IDX_CTRL, 8'h11);
    repeat (30) @(posedge core_clk);
    rd(split_timer_pkg::IDX_CTRL, v); `CHK("low flag", 8'h51, v)
    rd(split_timer_pkg::IDX_COUNT_LOW, v); `CHK("reloaded", 1'b1, v >= 8'hf0)
    rd(split_timer_pkg::IDX_COUNT_HIGH, v); `CHK("high idle", 8'h00, v)
    wr(split_timer_pkg::IDX_CTRL, 8'h50);
    repeat (2) @(posedge core_clk);
    `CHK("irq gated", 1'b0, timer_irq)
    wr(split_timer_pkg::IDX_CTRL, 8'h70);
    repeat (2) @(posedge core_clk);
    `CHK("irq enabled", 1'b1, timer_irq)
    wr(split_timer_pkg::IDX_IRQ_MASK, 8'h01);
    repeat (2) @(posedge core_clk);
    `CHK("status irq", 1'b1, irq)
    wr(split_timer_pkg::IDX_IRQ_STATUS, 8'h01);
    repeat (2) @(posedge core_clk);
    `CHK("status clear", 1'b0, irq)
    wr(split_timer_pkg::IDX_CTRL, 8'h20);
    repeat (2) @(posedge core_clk);
    `CHK("flag cleared", 1'b0, timer_irq)
    $display("test split_irq done");
  endtask

  task automatic t_wide_timer;
    wr(split_timer_pkg::IDX_CTRL, 8'h00);
    wr(split_timer_pkg::IDX_RELOAD_LOW, 8'h34);
    wr(split_timer_pkg::IDX_RELOAD_HIGH, 8'h12);
    wr(split_timer_pkg::IDX_COUNT_HIGH, 8'h00);
    wr(split_timer_pkg::IDX_COUNT_LOW, 8'hfd);
    wr(split_timer_pkg::IDX_CTRL, 8'h01);
    repeat (8) @(posedge core_clk);
    rd(split_timer_pkg::IDX_COUNT_HIGH, v); `CHK("carry", 8'h01, v)
    rd(split_timer_pkg::IDX_CTRL, v); `CHK("wide low flag", 8'h41, v)
    wr(split_timer_pkg::IDX_CTRL, 8'h00);
    wr(split_timer_pkg::IDX_COUNT_HIGH, 8'hff);
    wr(split_timer_pkg::IDX_COUNT_LOW, 8'hfd);
    wr(split_timer_pkg::IDX_CTRL, 8'h01);
    repeat (8) @(posedge core_clk);
    rd(split_timer_pkg::IDX_CTRL, v); `CHK("wide high flag", 8'h80, v & 8'h80)
    rd(split_timer_pkg::IDX_COUNT_HIGH, v); `CHK("wide reload", 8'h12, v)
    $display("test wide_timer done");
  endtask

  task automatic t_capture;
    wr(split_timer_pkg::IDX_CTRL, 8'h1c);
    wr(split_timer_pkg::IDX_COUNT_LOW, 8'h5a);
    wr(split_timer_pkg::IDX_COUNT_HIGH, 8'ha5);
    pulse(1'b0);
    rd(split_timer_pkg::IDX_RELOAD_LOW, v); `CHK("low capture", 8'h5a, v)
    rd(split_timer_pkg::IDX_CTRL, v); `CHK("low cap flag", 8'h5c, v)
    pulse(1'b1);
    rd(split_timer_pkg::IDX_RELOAD_HIGH, v); `CHK("high capture", 8'ha5, v)
    rd(split_timer_pkg::IDX_CTRL, v); `CHK("high cap flag", 8'hdc, v)
    wr(split_timer_pkg::IDX_CTRL, 8'h0c);
    wr(split_timer_pkg::IDX_COUNT_LOW, 8'h34);
    wr(split_timer_pkg::IDX_COUNT_HIGH, 8'h12);
    wr(split_timer_pkg::IDX_RELOAD_LOW, 8'h00);
    wr(split_timer_pkg::IDX_RELOAD_HIGH, 8'h00);
    pulse(1'b1);
    rd(split_timer_pkg::IDX_RELOAD_HIGH, v); `CHK("wide ignores high cap", 8'h00, v)
    pulse(1'b0);
    rd(split_timer_pkg::IDX_RELOAD_LOW, v); `CHK("wide cap low", 8'h34, v)
    rd(split_timer_pkg::IDX_RELOAD_HIGH, v); `CHK("wide cap high", 8'h12, v)
    rd(split_timer_pkg::IDX_CTRL, v); `CHK("wide cap flags", 8'h8c, v)
    wr(split_timer_pkg::IDX_CTRL, 8'h04);
    wr(split_timer_pkg::IDX_COUNT_HIGH, 8'hff);
    wr(split_timer_pkg::IDX_COUNT_LOW, 8'hfd);
    wr(split_timer_pkg::IDX_CTRL, 8'h05);
    repeat (8) @(posedge core_clk);
    rd(split_timer_pkg::IDX_CTRL, v); `CHK("seventeenth bit", 8'h40, v & 8'hc0)
    $display("test capture done");
  endtask

  task automatic t_split_high;
    wr(split_timer_pkg::IDX_CTRL, 8'h00);
    wr(split_timer_pkg::IDX_RELOAD_HIGH, 8'he0);
    wr(split_timer_pkg::IDX_COUNT_LOW, 8'h77);
    wr(split_timer_pkg::IDX_COUNT_HIGH, 8'hfe);
    wr(split_timer_pkg::IDX_CTRL, 8'h12);
    repeat (8) @(posedge core_clk);
    rd(split_timer_pkg::IDX_CTRL, v); `CHK("split high flag", 8'h92, v)
    rd(split_timer_pkg::IDX_COUNT_HIGH, v); `CHK("high reloaded", 1'b1, v >= 8'he0)
    rd(split_timer_pkg::IDX_COUNT_LOW, v); `CHK("low held", 8'h77, v)
    $display("test split_high done");
  endtask

  // ---------------------------------------------------------------
  // Sequence, watchdog and verdict
  // ---------------------------------------------------------------
  task automatic complete_run;
    $display("checks %0d mismatches %0d", total_checks, failures);
    if (failures == 0 && total_checks > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask

  initial begin
    failures = 0;
    total_checks = 0;
    rst = 1'b1;
    apb_req = '0;
    cap_low_trig = 1'b0;
    cap_high_trig = 1'b0;
    repeat (16) @(posedge core_clk);
    rst <= 1'b0;
    t_reset_map();
    t_split_irq();
    t_wide_timer();
    t_capture();
    t_split_high();
    complete_run();
  end

  initial begin
    #(40 * 20000);
    failures++;
    complete_run();
  end
endmodule // tb
